// file: design/pfc_core.sv
/*
  Program-flow core of a small 8-bit controller: program counter with a
  high holding register, return stack, indirect addressing and the
  interrupt control register, on one plain data access port.
  Assumes the sequencer gives one-cycle, mutually exclusive commands and
  the outer register file answers a read in the following cycle.
*/
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
module pfc_core (
  input  wire logic        core_clk,            // Core clock, 40 MHz
  input  wire logic        rst_n,               // Sync reset, active low
  input  wire logic        clk_en,              // Freezes all state
  input  wire logic [7:0]  reg_addr,            // Data port address
  input  wire logic [7:0]  reg_wdata,           // Data port write value
  input  wire logic        reg_wr,              // Write strobe
  input  wire logic        reg_rd,              // Read strobe
  output logic      [7:0]  reg_rdata,           // Read value, next cycle
  output logic      [7:0]  rf_addr,             // Register file address
  output logic      [7:0]  rf_wdata,            // Register file data
  output logic             rf_wr,               // Register file write
  output logic             rf_rd,               // Register file read
  input  wire logic [7:0]  rf_rdata,            // Register file answer
  input  wire logic        seq_inc,             // Advance counter
  input  wire logic        seq_call,            // Call: push and branch
  input  wire logic        seq_goto,            // Goto: branch only
  input  wire logic [10:0] seq_target,          // Branch target
  input  wire logic        seq_ret,             // Plain return
  input  wire logic        seq_ret_lit,         // Return with literal
  input  wire logic        seq_ret_irq,         // Return from interrupt
  input  wire logic        seq_irq_ack,         // Interrupt taken
  input  wire logic        timer_overflow_evt,  // Timer zero wrapped
  input  wire logic        ext_pin_evt,         // External pin edge
  input  wire logic        port_change_evt,     // Port change seen
  input  wire logic        nvm_write_done_flag, // Write-done flag level
  output logic      [12:0] pc_out,              // Program counter
  output logic      [8:0]  prog_addr,           // Program memory address
  output logic             irq_req              // Interrupt request
);

  // Maps a data address onto the block's own registers
  function automatic pfc_pkg::pfc_sel_t decode_sel(input logic [7:0] a);
    pfc_pkg::pfc_sel_t s;
    s = pfc_pkg::SEL_EXT;
    unique case (a)
      pfc_pkg::OFS_INDIRECT: s = pfc_pkg::SEL_IND;
      pfc_pkg::OFS_PC_LOW:   s = pfc_pkg::SEL_PCL;
      pfc_pkg::OFS_POINTER:  s = pfc_pkg::SEL_PTR;
      pfc_pkg::OFS_HOLD:     s = pfc_pkg::SEL_HOLD;
      pfc_pkg::OFS_INTERRUPT_CONTROL:   s = pfc_pkg::SEL_INTERRUPT_CONTROL;
      default:               s = pfc_pkg::SEL_EXT;
    endcase
    return s;
  endfunction : decode_sel

  // Counter, holding and pointer state
  logic [12:0] pc_r;
  logic [12:0] pc_nxt;
  logic [4:0]  hold_r;
  logic [4:0]  hold_nxt;
  logic [7:0]  ptr_r;
  logic [7:0]  ptr_nxt;

  // Read path state
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        ext_rd_r;
  logic        ext_rd_nxt;

  // Access resolution
  pfc_pkg::pfc_sel_t dir_sel;
  pfc_pkg::pfc_sel_t eff_sel;
  logic [7:0]  eff_addr;
  logic        null_acc;
  logic        wr_pcl;
  logic        wr_interrupt_control;

  // Stack hookup
  logic        stk_push;
  logic        stk_pop;
  logic [12:0] stk_top;
  logic [7:0]  interrupt_control;
  logic [12:0] branch_pc;

  // Indirect access retargets to the pointer address; the port has
  // no storage, so a pointer back at the port is a null access
  always_comb begin
    dir_sel  = decode_sel(reg_addr);
    eff_addr = reg_addr;
    eff_sel  = dir_sel;
    null_acc = 1'b0;
    if (dir_sel == pfc_pkg::SEL_IND) begin
      eff_addr = ptr_r;
      eff_sel  = decode_sel(ptr_r);
      null_acc = (eff_sel == pfc_pkg::SEL_IND);
    end
  end

  // Write decode for registers owned here
  assign wr_pcl    = reg_wr && !null_acc &&
                     eff_sel == pfc_pkg::SEL_PCL;
  assign wr_interrupt_control = reg_wr && !null_acc &&
                     eff_sel == pfc_pkg::SEL_INTERRUPT_CONTROL;

  // Outer register file sees only resolved, non-null accesses
  always_comb begin
    rf_addr  = eff_addr;
    rf_wdata = reg_wdata;
    rf_wr    = reg_wr && !null_acc &&
               eff_sel == pfc_pkg::SEL_EXT;
    rf_rd    = reg_rd && !null_acc &&
               eff_sel == pfc_pkg::SEL_EXT;
  end

  // Page bits of the holding register are dropped: memory ends
  // inside the first page, so a branch loads zero into the top two counter bits
  assign branch_pc = {2'h0, seq_target};

  // Stack traffic; holding register is never touched here
  assign stk_push = seq_irq_ack || seq_call;
  assign stk_pop  = !stk_push &&
                    (seq_ret || seq_ret_lit || seq_ret_irq);

  // Counter next value; a taken interrupt outranks the sequencer,
  // and a software low-byte write outranks plain advance
  always_comb begin
    pc_nxt = pc_r;
    if (seq_irq_ack) begin
      pc_nxt = pfc_pkg::IRQ_VECTOR;
    end else if (seq_call || seq_goto) begin
      pc_nxt = branch_pc;
    end else if (stk_pop) begin
      pc_nxt = stk_top;
    end else if (wr_pcl) begin
      pc_nxt = {hold_r, reg_wdata};
    end else if (seq_inc) begin
      pc_nxt = pc_r + 13'h0001;
    end
  end

  // Holding register and pointer; bits 7:5 of holding are absent
  always_comb begin
    hold_nxt = hold_r;
    ptr_nxt  = ptr_r;
    if (reg_wr && !null_acc && eff_sel == pfc_pkg::SEL_HOLD) begin
      hold_nxt = reg_wdata[4:0];
    end
    if (reg_wr && !null_acc && eff_sel == pfc_pkg::SEL_PTR) begin
      ptr_nxt = reg_wdata;
    end
  end

  // Read mux; the stack pointer has no address at all
  always_comb begin
    rdata_nxt  = rdata_r;
    ext_rd_nxt = 1'b0;
    if (reg_rd) begin
      rdata_nxt = 8'h00;
      if (!null_acc) begin
        unique case (eff_sel)
          pfc_pkg::SEL_PCL:    rdata_nxt = pc_r[7:0];
          pfc_pkg::SEL_PTR:    rdata_nxt = ptr_r;
          pfc_pkg::SEL_HOLD:   rdata_nxt = {3'h0, hold_r};
          pfc_pkg::SEL_INTERRUPT_CONTROL: rdata_nxt = interrupt_control;
          pfc_pkg::SEL_EXT:    ext_rd_nxt = 1'b1;
          pfc_pkg::SEL_IND:    rdata_nxt = 8'h00;
        endcase
      end
    end
  end

  // Registers only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pc_r     <= pfc_pkg::PC_RST;
      hold_r   <= pfc_pkg::HOLD_RST;
      ptr_r    <= pfc_pkg::POINTER_RST;
      rdata_r  <= 8'h00;
      ext_rd_r <= 1'b0;
    end else if (clk_en) begin
      pc_r     <= pc_nxt;
      hold_r   <= hold_nxt;
      ptr_r    <= ptr_nxt;
      rdata_r  <= rdata_nxt;
      ext_rd_r <= ext_rd_nxt;
    end
  end

  // Outer file answers itself one cycle after its strobe
  assign reg_rdata = ext_rd_r ? rf_rdata : rdata_r;

  // Counter as seen by program memory; 512 words use nine bits
  assign pc_out    = pc_r;
  assign prog_addr = pc_r[8:0];

  // Eight-entry circular stack, overflow is silent by design
  pfc_ret_stack u_stack (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .push     (stk_push),
    .pop      (stk_pop),
    .push_pc  (pc_r),
    .top_pc   (stk_top)
  );

  // Interrupt control register and request
  pfc_irq_ctrl u_irq (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .wr       (wr_interrupt_control),
    .wdata    (reg_wdata),
    .tmr_evt  (timer_overflow_evt),
    .ext_evt  (ext_pin_evt),
    .port_evt (port_change_evt),
    .nvm_flag (nvm_write_done_flag),
    .interrupt_control   (interrupt_control),
    .irq_req  (irq_req)
  );

endmodule : pfc_core

// file: include/pfc_pkg.sv
/*
  Shared constants and types for the program-flow core: widths, register
  offsets, field positions, reset values and the register select codes.
  Assumes a single core clock and no other package.
*/
package pfc_pkg;

  // Data path and address widths
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 8;
  localparam int PC_W      = 13;
  localparam int HOLD_W    = 5;
  localparam int BR_W      = 11;
  localparam int PMEM_AW   = 9;
  localparam int PMEM_WORDS = 512;

  // Return stack geometry
  localparam int STK_DEPTH = 8;
  localparam int STK_PTR_W = 3;

  // Register offsets on the data port
  localparam logic [7:0] OFS_INDIRECT = 8'h00;
  localparam logic [7:0] OFS_PC_LOW   = 8'h02;
  localparam logic [7:0] OFS_POINTER  = 8'h04;
  localparam logic [7:0] OFS_HOLD     = 8'h0a;
  localparam logic [7:0] OFS_INTERRUPT_CONTROL   = 8'h0b;

  // Interrupt control field positions
  localparam int IC_GIE     = 7;
  localparam int IC_NVM_IE  = 6;
  localparam int IC_TMR_IE  = 5;
  localparam int IC_EXT_IE  = 4;
  localparam int IC_PORT_IE = 3;
  localparam int IC_TMR_IF  = 2;
  localparam int IC_EXT_IF  = 1;
  localparam int IC_PORT_IF = 0;

  // Page select bits of the high holding register
  localparam int HOLD_PAGE_HI = 4;
  localparam int HOLD_PAGE_LO = 3;

  // Values after reset
  localparam logic [7:0]  INTERRUPT_CONTROL_RST  = 8'h00;
  localparam logic [12:0] PC_RST      = 13'h0000;
  localparam logic [4:0]  HOLD_RST    = 5'h00;
  localparam logic [7:0]  POINTER_RST = 8'h00;
  localparam logic [12:0] STK_RST     = 13'h0000;

  // Interrupt vector, plain default
  localparam logic [12:0] IRQ_VECTOR  = 13'h0004;

  // Target of a data access
  typedef enum logic [2:0] {
    SEL_EXT    = 3'h0,
    SEL_IND    = 3'h1,
    SEL_PCL    = 3'h2,
    SEL_PTR    = 3'h3,
    SEL_HOLD   = 3'h4,
    SEL_INTERRUPT_CONTROL = 3'h5
  } pfc_sel_t;

endpackage : pfc_pkg

// file: design/pfc_ret_stack.sv
/*
  Eight-entry circular return-address stack with a hidden pointer.
  Assumes push and pop are one-cycle pulses, never both at once.
*/
`timescale 1ns/10ps
module pfc_ret_stack (
  input  wire logic        core_clk,  // Core clock
  input  wire logic        rst_n,     // Sync reset, active low
  input  wire logic        clk_en,    // Freezes state when low
  input  wire logic        push,      // Store push_pc
  input  wire logic        pop,       // Drop top entry
  input  wire logic [12:0] push_pc,   // Address to save
  output logic      [12:0] top_pc     // Entry a pop returns
);

  logic [12:0] mem_r   [pfc_pkg::STK_DEPTH];
  logic [12:0] mem_nxt [pfc_pkg::STK_DEPTH];
  logic [2:0]  ptr_r;
  logic [2:0]  ptr_nxt;

  // Pointer wraps freely; no overflow or underflow flag exists
  always_comb begin
    ptr_nxt = ptr_r;
    if (push) begin
      ptr_nxt = ptr_r + 3'h1;
    end else if (pop) begin
      ptr_nxt = ptr_r - 3'h1;
    end
  end

  // One next-value process per entry
  for (genvar i = 0; i < pfc_pkg::STK_DEPTH; i++) begin : g_ent
    always_comb begin
      mem_nxt[i] = mem_r[i];
      if (push && ptr_r == 3'(i)) begin
        mem_nxt[i] = push_pc;
      end
    end
  end

  // Top entry sits just below the pointer
  assign top_pc = mem_r[ptr_r - 3'h1];

  // Registers only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ptr_r <= 3'h0;
      for (int k = 0; k < pfc_pkg::STK_DEPTH; k++) begin
        mem_r[k] <= pfc_pkg::STK_RST;
      end
    end else if (clk_en) begin
      ptr_r <= ptr_nxt;
      mem_r <= mem_nxt;
    end
  end

endmodule : pfc_ret_stack

// file: design/pfc_irq_ctrl.sv
/*
  Interrupt control register: enables, sticky flags, global enable and
  the request to the core. Assumes events are one-cycle pulses.
*/
`timescale 1ns/10ps
module pfc_irq_ctrl (
  input  wire logic       core_clk,     // Core clock
  input  wire logic       rst_n,        // Sync reset, active low
  input  wire logic       clk_en,       // Freezes state when low
  input  wire logic       wr,           // Software write
  input  wire logic [7:0] wdata,        // Write value
  input  wire logic       tmr_evt,      // Timer overflow pulse
  input  wire logic       ext_evt,      // External pin pulse
  input  wire logic       port_evt,     // Port change pulse
  input  wire logic       nvm_flag,     // Write-done flag level
  output logic      [7:0] interrupt_control,       // Register contents
  output logic            irq_req       // Request to the core
);

  logic [7:0] ic_r;
  logic [7:0] ic_nxt;
  logic       req_r;
  logic       req_nxt;

  // Write first, then events, so a set beats a clear
  always_comb begin
    ic_nxt = ic_r;
    if (wr) begin
      ic_nxt = wdata;
    end
    if (tmr_evt) begin
      ic_nxt[pfc_pkg::IC_TMR_IF] = 1'b1;
    end
    if (ext_evt) begin
      ic_nxt[pfc_pkg::IC_EXT_IF] = 1'b1;
    end
    if (port_evt) begin
      ic_nxt[pfc_pkg::IC_PORT_IF] = 1'b1;
    end
  end

  // Request follows the register with no added delay
  always_comb begin
    req_nxt = ic_nxt[pfc_pkg::IC_GIE] && (
      (ic_nxt[pfc_pkg::IC_TMR_IE] && ic_nxt[pfc_pkg::IC_TMR_IF])
      || (ic_nxt[pfc_pkg::IC_EXT_IE] && ic_nxt[pfc_pkg::IC_EXT_IF])
      || (ic_nxt[pfc_pkg::IC_PORT_IE] && ic_nxt[pfc_pkg::IC_PORT_IF])
      || (ic_nxt[pfc_pkg::IC_NVM_IE] && nvm_flag));
  end

  assign interrupt_control  = ic_r;
  assign irq_req = req_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ic_r  <= pfc_pkg::INTERRUPT_CONTROL_RST;
      req_r <= 1'b0;
    end else if (clk_en) begin
      ic_r  <= ic_nxt;
      req_r <= req_nxt;
    end
  end

endmodule : pfc_irq_ctrl

// file: verification/pfc_core_checker.sv
/*
  Port checker for the program-flow core, bound to pfc_core.
  Assumes one clock domain and commands given as one-cycle pulses.
*/
`timescale 1ns/10ps
module pfc_core_checker (
  input wire logic        core_clk,            // Core clock
  input wire logic        rst_n,               // Sync reset
  input wire logic        clk_en,              // Clock enable
  input wire logic [7:0]  reg_addr,            // Port address
  input wire logic [7:0]  reg_wdata,           // Port write data
  input wire logic        reg_wr,              // Write strobe
  input wire logic [7:0]  reg_rdata,           // Read data
  input wire logic        rf_rd,               // Outer read
  input wire logic [7:0]  rf_rdata,            // Outer answer
  input wire logic        seq_inc,             // Advance
  input wire logic        seq_call,            // Call
  input wire logic        seq_goto,            // Goto
  input wire logic [10:0] seq_target,          // Branch target
  input wire logic        seq_ret,             // Return
  input wire logic        seq_ret_lit,         // Return literal
  input wire logic        seq_ret_irq,         // Return interrupt
  input wire logic        seq_irq_ack,         // Interrupt taken
  input wire logic [12:0] pc_out,              // Counter
  input wire logic [8:0]  prog_addr,           // Memory address
  input wire logic        irq_req,             // Request
  input wire logic        timer_overflow_evt,  // Timer event
  input wire logic        ext_pin_evt,         // Pin event
  input wire logic        port_change_evt,     // Port event
  input wire logic        nvm_write_done_flag  // Write-done level
);
  // Any sequencer command or interrupt cause in this cycle
  wire logic seq_any = seq_inc | seq_call | seq_goto | seq_ret
                     | seq_ret_lit | seq_ret_irq | seq_irq_ack;
  wire logic cause = timer_overflow_evt | ext_pin_evt | port_change_evt
                   | reg_wr | nvm_write_done_flag;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_IRQ_VECTOR: assert property (seq_irq_ack && clk_en |=>
    pc_out == pfc_pkg::IRQ_VECTOR) else $error("vector not loaded");
  AST_BRANCH: assert property ((seq_call || seq_goto) && !seq_irq_ack
    && clk_en |=> pc_out == {2'b00, $past(seq_target)})
    else $error("branch target wrong");
  AST_PROG_ADDR: assert property (prog_addr == pc_out[8:0])
    else $error("program address differs from counter");
  AST_RF_PASS: assert property (rf_rd && clk_en |=>
    reg_rdata == rf_rdata) else $error("outer read not passed");
  AST_IRQ_CAUSE: assert property ($rose(irq_req) |-> $past(cause))
    else $error("request rose without cause");
  AST_PC_HOLD: assert property (!seq_any && !reg_wr |=>
    $stable(pc_out)) else $error("counter moved on its own");
  AST_INC: assert property (seq_inc && clk_en && !reg_wr
    && !(seq_any & ~seq_inc) |=> pc_out == $past(pc_out) + 13'h0001)
    else $error("increment wrong");
  AST_LOW_WRITE: assert property (reg_wr && clk_en && !seq_any
    && reg_addr == pfc_pkg::OFS_PC_LOW |=> pc_out[7:0] == $past(reg_wdata))
    else $error("low byte write lost");
endmodule : pfc_core_checker

bind pfc_core pfc_core_checker u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .rf_rd(rf_rd), .rf_rdata(rf_rdata),
  .seq_inc(seq_inc), .seq_call(seq_call), .seq_goto(seq_goto),
  .seq_target(seq_target), .seq_ret(seq_ret), .seq_ret_lit(seq_ret_lit),
  .seq_ret_irq(seq_ret_irq), .seq_irq_ack(seq_irq_ack),
  .pc_out(pc_out), .prog_addr(prog_addr), .irq_req(irq_req),
  .timer_overflow_evt(timer_overflow_evt), .ext_pin_evt(ext_pin_evt),
  .port_change_evt(port_change_evt),
  .nvm_write_done_flag(nvm_write_done_flag));

// file: verification/pfc_rf_model.sv
/*
  Outer register file model behind the core's data access port.
  Assumes read data are wanted only in the cycle after rf_rd.
*/
`timescale 1ns/10ps
module pfc_rf_model (
  input  wire logic       core_clk,  // Core clock
  input  wire logic [7:0] rf_addr,   // Resolved address
  input  wire logic [7:0] rf_wdata,  // Write data
  input  wire logic       rf_wr,     // Write strobe
  input  wire logic       rf_rd,     // Read strobe
  output logic      [7:0] rf_rdata   // Answer
);
  logic [7:0] mem [256];
  logic [7:0] q_r;
  logic       valid_r;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    q_r = 8'h00;
    valid_r = 1'b0;
  end

  // Store writes and capture reads for the following cycle
  always @(posedge core_clk) begin
    if (rf_wr) mem[rf_addr] <= rf_wdata;
    if (rf_rd) q_r <= mem[rf_addr];
    valid_r <= rf_rd;
  end

  // Stale answers are inverted so they never pass for fresh data
  assign rf_rdata = valid_r ? q_r : ~q_r;
endmodule : pfc_rf_model

// file: verification/test_pc_stack_indirect_irq_ctrl.sv
/*
  Self-checking bench for the program-flow core with a register file model.
  Assumes the core's package and the bound checker are compiled first.
*/
`timescale 1ns/10ps
module test_pc_stack_indirect_irq_ctrl;
  localparam logic [6:0] C_INC = 7'h40, C_CALL = 7'h20, C_GOTO = 7'h10;
  localparam logic [6:0] C_RET = 7'h08, C_RLIT = 7'h04, C_RIRQ = 7'h02;
  localparam logic [6:0] C_ACK = 7'h01;
  logic        core_clk, rst_n, clk_en, reg_wr, reg_rd, rf_wr, rf_rd;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rf_addr, rf_wdata, rf_rdata;
  logic [6:0]  cmd;
  logic [2:0]  evt;
  logic        nvm_flag, irq_req;
  logic [10:0] seq_target;
  logic [12:0] pc_out;
  logic [8:0]  prog_addr;
  int          fails, comparisons;

  pfc_core u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rf_addr(rf_addr),
    .rf_wdata(rf_wdata), .rf_wr(rf_wr), .rf_rd(rf_rd), .rf_rdata(rf_rdata),
    .seq_inc(cmd[6]), .seq_call(cmd[5]), .seq_goto(cmd[4]),
    .seq_target(seq_target), .seq_ret(cmd[3]), .seq_ret_lit(cmd[2]),
    .seq_ret_irq(cmd[1]), .seq_irq_ack(cmd[0]),
    .timer_overflow_evt(evt[2]), .ext_pin_evt(evt[1]),
    .port_change_evt(evt[0]), .nvm_write_done_flag(nvm_flag),
    .pc_out(pc_out), .prog_addr(prog_addr), .irq_req(irq_req));

  pfc_rf_model u_rf (
    .core_clk(core_clk), .rf_addr(rf_addr), .rf_wdata(rf_wdata),
    .rf_wr(rf_wr), .rf_rd(rf_rd), .rf_rdata(rf_rdata));

  // Compare and count
  task automatic chk(input string what, input logic [12:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle write strobe; returns once the edge has taken it
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Read strobe, then judge the data in the answer cycle
  task automatic rchk(input logic [7:0] a, exp, input string what);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(what, {5'h00, exp}, {5'h00, reg_rdata});
  endtask : rchk

  // One sequencer command pulse
  task automatic seq(input logic [6:0] c, input logic [10:0] t);
    @(posedge core_clk);
    cmd <= c;
    seq_target <= t;
    @(posedge core_clk);
    cmd <= 7'h00;
    #1;
  endtask : seq

  // Event pulses on timer, pin and port inputs
  task automatic pulse(input logic [2:0] e);
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= 3'h0;
    #1;
  endtask : pulse

  task automatic t_ctrl();
    rchk(pfc_pkg::OFS_INTERRUPT_CONTROL, 8'h00, "control reset");
    wr(pfc_pkg::OFS_INTERRUPT_CONTROL, 8'h5a);
    rchk(pfc_pkg::OFS_INTERRUPT_CONTROL, 8'h5a, "control rw");
    chk("request without global", 13'h0, irq_req);
    wr(pfc_pkg::OFS_INTERRUPT_CONTROL, 8'h00);
    pulse(3'b100);
    rchk(pfc_pkg::OFS_INTERRUPT_CONTROL, 8'h04, "timer flag");
    pulse(3'b011);
    rchk(pfc_pkg::OFS_INTERRUPT_CONTROL, 8'h07, "pin and port flags");
    wr(pfc_pkg::OFS_INTERRUPT_CONTROL, 8'h27);
    chk("global clear blocks", 13'h0, irq_req);
    wr(pfc_pkg::OFS_INTERRUPT_CONTROL, 8'ha7);
    chk("timer request", 13'h1, irq_req);
    wr(pfc_pkg::OFS_INTERRUPT_CONTROL, 8'h87);
    chk("no enable no request", 13'h0, irq_req);
    wr(pfc_pkg::OFS_INTERRUPT_CONTROL, 8'h90);
    pulse(3'b010);
    chk("pin request", 13'h1, irq_req);
    wr(pfc_pkg::OFS_INTERRUPT_CONTROL, 8'hc0);
    chk("write-done idle", 13'h0, irq_req);
    @(posedge core_clk);
    nvm_flag <= 1'b1;
    @(posedge core_clk);
    #1 chk("write-done request", 13'h1, irq_req);
    $display("test control done");
  endtask : t_ctrl

  task automatic t_pc();
    wr(pfc_pkg::OFS_HOLD, 8'h07);
    wr(pfc_pkg::OFS_PC_LOW, 8'h34);
    chk("low write", 13'h0734, pc_out);
    rchk(pfc_pkg::OFS_PC_LOW, 8'h34, "low read");
    seq(C_GOTO, 11'h7ff);
    chk("goto", 13'h07ff, pc_out);
    seq(C_INC, 11'h000);
    chk("increment", 13'h0800, pc_out);
    chk("program address", 13'h0000, {4'h0, prog_addr});
    // Clock enable low must swallow a command
    @(posedge core_clk);
    clk_en <= 1'b0;
    seq(C_INC, 11'h000);
    chk("frozen counter", 13'h0800, pc_out);
    @(posedge core_clk);
    clk_en <= 1'b1;
    $display("test counter done");
  endtask : t_pc

  task automatic t_stack();
    seq(C_GOTO, 11'h100);
    for (int k = 1; k <= 9; k++) seq(C_CALL, 11'(11'h100 + k));
    for (int j = 1; j <= 9; j++) begin
      seq(j % 3 == 0 ? C_RIRQ : (j % 3 == 1 ? C_RET : C_RLIT), 11'h000);
      chk("pop", j == 9 ? 13'h0108 : 13'(13'h0109 - j), pc_out);
    end
    rchk(pfc_pkg::OFS_HOLD, 8'h07, "holding kept");
    seq(C_ACK, 11'h000);
    chk("vector", 13'h0004, pc_out);
    seq(C_RIRQ, 11'h000);
    chk("return from vector", 13'h0108, pc_out);
    $display("test stack done");
  endtask : t_stack

  task automatic t_ind();
    wr(pfc_pkg::OFS_POINTER, 8'h20);
    wr(pfc_pkg::OFS_INDIRECT, 8'h5a);
    rchk(pfc_pkg::OFS_INDIRECT, 8'h5a, "indirect read");
    rchk(8'h20, 8'h5a, "direct view");
    wr(pfc_pkg::OFS_POINTER, 8'h00);
    wr(pfc_pkg::OFS_INDIRECT, 8'h77);
    rchk(pfc_pkg::OFS_INDIRECT, 8'h00, "self read");
    chk("self write", 13'h0, {5'h00, u_rf.mem[0]});
    $display("test indirect done");
  endtask : t_ind

  // Mid-run reset brings counter and control back to zero
  task automatic t_rst();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 chk("counter after reset", 13'h0000, pc_out);
    chk("request after reset", 13'h0, irq_req);
    rchk(pfc_pkg::OFS_INTERRUPT_CONTROL, 8'h00, "control after reset");
    $display("test reset done");
  endtask : t_rst

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // 40 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    {reg_wr, reg_rd, nvm_flag} = 3'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    cmd = 7'h00;
    evt = 3'h0;
    seq_target = 11'h000;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    t_ctrl();
    t_pc();
    t_stack();
    t_ind();
    t_rst();
    summarize();
  end

  // Watchdog, far beyond the hundred or so cycles the scenarios need
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule : test_pc_stack_indirect_irq_ctrl
